// [design/sdram_burst_regs.svh]
// register map, status field positions and fixed codes of the sdram burst block
`ifndef SDRAM_BURST_REGS_SVH
`define SDRAM_BURST_REGS_SVH

`define STATUS_OFF    8'h00
`define CTRL_OFF      8'h04
`define CTRL_RST      32'h0000_0001
`define CTRL_EN_BIT   0
`define STS_MODE_LSB  0
`define STS_BANK_LSB  12
`define STS_REF_LSB   16
`define STS_MRS_BIT   20
`define STS_RD_BIT    21
`define STS_WR_BIT    22
`define AP_BIT        10
`define BL_1          3'h0
`define BL_2          3'h1
`define BL_4          3'h2
`define BL_8          3'h3
`define BL_FP         3'h7
`define CL_3          3'h3
`define REF_INIT      4'h8
`define MASK_BL2      8'h01
`define MASK_BL4      8'h03
`define MASK_BL8      8'h07
`define MASK_FP       8'hff
`define MASK_BL1      8'h00
`define LEN_FP        9'h100
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// [design/sdram_burst_pkg.sv]
// types shared by the sdram burst block
package sdram_burst_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b100
  } burst_state_t;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [11:0] addr;
    logic [1:0]  dqm;
    logic [15:0] dq;
  } pins_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       wb;
    logic [1:0] rsv_lo;
    logic [2:0] cl;
    logic       bt;
    logic [2:0] bl;
  } mode_t;

  typedef struct packed {
    logic       v;
    logic [7:0] idx;
  } rd_slot_t;

endpackage : sdram_burst_pkg

// [design/sdram_burst.sv]
// sdram command decoder, burst engine, small data array and axi4-lite status port
`timescale 1ns/1ps
`include "sdram_burst_regs.svh"

module sdram_burst
  import sdram_burst_pkg::*;
(
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // sdram pins
  input  wire logic        sd_clk,
  input  wire pins_t       sd_pins,
  output logic [15:0]      dq_o,
  output logic [1:0]       dq_oe
);

  // two-stage synchronisers; stage one feeds stage two only
  pins_t        pin_s1_q, pin_s2_q;
  logic         clk_s1_q, clk_s2_q, clk_s3_q;
  logic         rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
    end else if (ce) begin
      pin_s1_q <= sd_pins;
      pin_s2_q <= pin_s1_q;
      clk_s1_q <= sd_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end

  assign rise = clk_s2_q & ~clk_s3_q;

  // column address of beat idx for the programmed burst
  function automatic logic [7:0] col_of(input logic [7:0] start, input logic [7:0] idx, input mode_t m);
    logic [7:0] msk;
    logic [7:0] sum;
    msk = `MASK_BL1;
    sum = start + idx;
    case (m.bl)
      `BL_2:   msk = `MASK_BL2;
      `BL_4:   msk = `MASK_BL4;
      `BL_8:   msk = `MASK_BL8;
      `BL_FP:  msk = `MASK_FP;
      default: msk = `MASK_BL1;
    endcase
    if (m.bt && m.bl != `BL_FP)
      col_of = start ^ (idx & msk);
    else
      col_of = (start & ~msk) | (sum & msk);
  endfunction : col_of

  // beats in a burst; full page never ends on its own
  function automatic logic [8:0] len_of(input mode_t m);
    case (m.bl)
      `BL_2:   len_of = 9'h002;
      `BL_4:   len_of = 9'h004;
      `BL_8:   len_of = 9'h008;
      `BL_FP:  len_of = `LEN_FP;
      default: len_of = 9'h001;
    endcase
  endfunction : len_of

  // registers
  logic [31:0]  ctrl_q;
  mode_t        mode_q;
  logic         mrs_done_q;
  logic [3:0]   ref_cnt_q;
  logic [3:0]   bank_open_q;
  burst_state_t st_q;
  logic [7:0]   cnt_q;
  logic [7:0]   start_q;
  logic [1:0]   bank_q;
  logic [8:0]   len_q;
  logic         ap_q;
  rd_slot_t     rpipe_q [0:1];
  logic [1:0]   dqm_d1_q;
  logic [15:0]  mem [0:255];

  // command decode, only on a detected link clock edge
  logic         cmd_ok, is_mrs, is_act, is_pre, is_ref, is_rd, is_wr, is_bst, is_col;
  assign cmd_ok = rise & ctrl_q[`CTRL_EN_BIT] & pin_s2_q.cke & ~pin_s2_q.cs_n;
  assign is_mrs = cmd_ok & ~pin_s2_q.ras_n & ~pin_s2_q.cas_n & ~pin_s2_q.we_n;
  assign is_act = cmd_ok & ~pin_s2_q.ras_n &  pin_s2_q.cas_n &  pin_s2_q.we_n;
  assign is_pre = cmd_ok & ~pin_s2_q.ras_n &  pin_s2_q.cas_n & ~pin_s2_q.we_n;
  assign is_ref = cmd_ok & ~pin_s2_q.ras_n & ~pin_s2_q.cas_n &  pin_s2_q.we_n;
  assign is_rd  = cmd_ok &  pin_s2_q.ras_n & ~pin_s2_q.cas_n &  pin_s2_q.we_n;
  assign is_wr  = cmd_ok &  pin_s2_q.ras_n & ~pin_s2_q.cas_n & ~pin_s2_q.we_n;
  assign is_bst = cmd_ok &  pin_s2_q.ras_n &  pin_s2_q.cas_n & ~pin_s2_q.we_n;
  assign is_col = is_rd | is_wr;

  // current beat: a column command always wins over the running burst
  logic         beat_v, beat_rd, run_step, step_last, cmd_last, end_burst;
  logic [7:0]   beat_col, cnt_nx;
  logic [1:0]   beat_bank;
  logic [8:0]   cmd_len;

  assign cnt_nx   = cnt_q + 8'h01;
  assign run_step = rise & pin_s2_q.cke & (st_q != ST_IDLE) & ~is_col & ~is_bst;
  assign step_last = (len_q != `LEN_FP) && ({1'b0, cnt_nx} == len_q - 9'h001);
  // single-word write mode turns every write into one beat
  assign cmd_len  = (is_wr && mode_q.wb) ? 9'h001 : len_of(mode_q);
  assign cmd_last = (cmd_len == 9'h001);

  always_comb begin
    beat_v    = 1'b0;
    beat_rd   = 1'b0;
    beat_col  = 8'h00;
    beat_bank = 2'h0;
    if (is_col) begin
      beat_v    = 1'b1;
      beat_rd   = is_rd;
      beat_col  = pin_s2_q.addr[7:0];
      beat_bank = pin_s2_q.ba;
    end else if (run_step) begin
      beat_v    = 1'b1;
      beat_rd   = (st_q == ST_RD);
      beat_col  = col_of(start_q, cnt_nx, mode_q);
      beat_bank = bank_q;
    end
  end

  assign end_burst = (is_col & cmd_last) | (run_step & step_last);

  // burst engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 8'h00;
      start_q <= 8'h00;
      bank_q  <= 2'h0;
      len_q   <= 9'h001;
      ap_q    <= 1'b0;
    end else if (ce) begin
      if (is_col) begin
        // a new column command restarts at full length, a single-word write at one beat
        cnt_q   <= 8'h00;
        start_q <= pin_s2_q.addr[7:0];
        bank_q  <= pin_s2_q.ba;
        len_q   <= cmd_len;
        ap_q    <= pin_s2_q.addr[`AP_BIT];
        if (cmd_last)
          st_q <= ST_IDLE;
        else
          st_q <= is_rd ? ST_RD : ST_WR;
      end else if (is_bst) begin
        st_q <= ST_IDLE;
      end else if (run_step) begin
        cnt_q <= cnt_nx;
        if (step_last)
          st_q <= ST_IDLE;
      end
    end
  end

  // mode register and init bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q     <= '0;
      mrs_done_q <= 1'b0;
      ref_cnt_q  <= 4'h0;
    end else if (ce) begin
      if (is_mrs) begin
        mode_q     <= mode_t'(pin_s2_q.addr);
        mrs_done_q <= 1'b1;
      end
      if (is_ref && ref_cnt_q != `REF_INIT)
        ref_cnt_q <= ref_cnt_q + 4'h1;
    end
  end

  // open-bank tracking; the burst only reads it for status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_open_q <= 4'h0;
    end else if (ce) begin
      if (is_act)
        bank_open_q[pin_s2_q.ba] <= 1'b1;
      else if (is_pre && pin_s2_q.addr[`AP_BIT])
        bank_open_q <= 4'h0;
      else if (is_pre)
        bank_open_q[pin_s2_q.ba] <= 1'b0;
      else if (end_burst && (is_col ? pin_s2_q.addr[`AP_BIT] : ap_q))
        bank_open_q[is_col ? pin_s2_q.ba : bank_q] <= 1'b0;
    end
  end

  // write beats take data of the same edge, masked per byte
  always_ff @(posedge aclk) begin
    if (ce && beat_v && !beat_rd) begin
      if (!pin_s2_q.dqm[0])
        mem[{beat_bank, beat_col[5:0]}][7:0] <= pin_s2_q.dq[7:0];
      if (!pin_s2_q.dqm[1])
        mem[{beat_bank, beat_col[5:0]}][15:8] <= pin_s2_q.dq[15:8];
    end
  end

  // read pipeline; older beats keep flowing after an interrupting read
  rd_slot_t     rd_src;
  assign rd_src = (mode_q.cl == `CL_3) ? rpipe_q[1] : rpipe_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rpipe_q[0] <= '0;
      rpipe_q[1] <= '0;
      dqm_d1_q   <= 2'h0;
      dq_o       <= 16'h0000;
      dq_oe      <= 2'h0;
    end else if (ce && rise) begin
      rpipe_q[0] <= '{v: beat_v & beat_rd, idx: {beat_bank, beat_col[5:0]}};
      rpipe_q[1] <= rpipe_q[0];
      dqm_d1_q   <= pin_s2_q.dqm;
      dq_o       <= mem[rd_src.idx];
      // a write beat owns the bus, so the driver backs off even if unmasked
      // mask of link edge e-1 gates the data sampled at e+1: two edges of mask latency
      dq_oe      <= {2{rd_src.v & ~(beat_v & ~beat_rd)}} & ~dqm_d1_q;
    end
  end

  // axi4-lite: write takes address and data together
  logic         wr_go;
  logic [31:0]  sts;
  assign s_awready = ce & s_awvalid & s_wvalid & ~s_bvalid;
  assign s_wready  = s_awready;
  assign wr_go     = s_awready;
  assign s_arready = ce & ~s_rvalid;

  always_comb begin
    sts = 32'h0000_0000;
    sts[`STS_MODE_LSB +: 12] = mode_q;
    sts[`STS_BANK_LSB +: 4]  = bank_open_q;
    sts[`STS_REF_LSB +: 4]   = ref_cnt_q;
    sts[`STS_MRS_BIT]        = mrs_done_q;
    sts[`STS_RD_BIT]         = (st_q == ST_RD);
    sts[`STS_WR_BIT]         = (st_q == ST_WR);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= `CTRL_RST;
      s_bvalid <= 1'b0;
      s_bresp  <= `RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (s_awaddr == `CTRL_OFF) ? `RESP_OKAY : `RESP_SLVERR;
        if (s_awaddr == `CTRL_OFF && s_wstrb[0])
          ctrl_q[`CTRL_EN_BIT] <= s_wdata[`CTRL_EN_BIT];
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= `RESP_OKAY;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= `RESP_OKAY;
        s_rdata  <= 32'h0000_0000;
        if (s_araddr == `STATUS_OFF)
          s_rdata <= sts;
        else if (s_araddr == `CTRL_OFF)
          s_rdata <= ctrl_q;
        else
          s_rresp <= `RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // checks
  sequence read_cmd_s;
    ce && is_rd;
  endsequence

  sequence burst_restart_s;
    cnt_q == 8'h00 && start_q == $past(pin_s2_q.addr[7:0]);
  endsequence

  mode_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && is_mrs |=> mode_q == $past(pin_s2_q.addr))
    else $error("mode register not loaded from address");

  read_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    read_cmd_s |=> burst_restart_s and (st_q == ST_RD || len_q == 9'h001))
    else $error("read did not restart burst");

  write_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && is_wr && !mode_q.wb |=> burst_restart_s and (len_q == len_of(mode_q)))
    else $error("write did not restart at full length");

  col_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_col |-> beat_v && beat_rd == is_rd && beat_col == pin_s2_q.addr[7:0])
    else $error("column command not taken");

  stop_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && is_bst |=> st_q == ST_IDLE && $stable(bank_open_q))
    else $error("burst stop left burst running");

  seq_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_step && !mode_q.bt && mode_q.bl == `BL_8 |-> beat_col[7:3] == start_q[7:3])
    else $error("sequential burst carried out of block");

  ilv_col_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_step && mode_q.bt && mode_q.bl == `BL_4 |-> beat_col == (start_q ^ (cnt_nx & `MASK_BL4)))
    else $error("interleaved column wrong");

  page_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && run_step && len_q == `LEN_FP && cnt_q == 8'hff |=> cnt_q == 8'h00 && st_q != ST_IDLE)
    else $error("full page burst did not wrap");

  read_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rise && rd_src.v && !(beat_v && !beat_rd) && dqm_d1_q == 2'h0 |=> dq_oe == 2'h3)
    else $error("read data not driven at latency");

  write_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && is_rd && st_q == ST_WR |-> !(beat_v && !beat_rd))
    else $error("write beat taken with read command");

endmodule : sdram_burst

// [verif/sdram_ctrl_model.sv]
// memory controller model driving the link pins of the sdram burst block
`timescale 1ns/1ps
module sdram_ctrl_model
  import sdram_burst_pkg::*;
(
  // link pins
  output logic             sd_clk,
  output pins_t            sd_pins,
  // read data from the block
  input  wire logic [15:0] dq_o,
  input  wire logic [1:0]  dq_oe
);
  int          edge_n = 0;
  logic [1:0]  dqm_q = 2'h0;
  logic [15:0] cap_d [0:2047];
  logic [1:0]  cap_oe [0:2047];

  // nop with cke and mask high during the power-up pause
  initial begin
    sd_clk  = 1'b0;
    sd_pins = {1'b1, 4'h7, 2'h0, 12'h0, 2'h3, 16'h0};
    forever #400 sd_clk = ~sd_clk;
  end

  // read pins as the controller samples them at each rise
  always @(posedge sd_clk) begin
    cap_d[edge_n]  <= dq_o;
    cap_oe[edge_n] <= dq_oe;
    edge_n         <= edge_n + 1;
  end

  // launched on the fall so the pins are settled well before the block samples them
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a, input logic [15:0] d,
                     output int k);
    @(negedge sd_clk);
    k = edge_n;
    sd_pins <= {1'b1, c, ba, a, dqm_q, d};
  endtask : cmd

  // released bus: pattern changes every cycle so stale data never looks valid
  task automatic nop(input int n);
    int k;
    repeat (n) cmd(4'h7, 2'h0, 12'h0, 16'h5a5a ^ 16'(edge_n), k);
  endtask : nop

  task automatic set_mode(input logic [11:0] m);
    int k;
    cmd(4'h2, 2'h0, 12'h400, 16'h0, k);
    nop(1);
    cmd(4'h0, 2'h0, m, 16'h0, k);
    nop(2);
  endtask : set_mode

  task automatic init(input logic [11:0] m);
    int k;
    repeat (250) @(posedge sd_clk);
    set_mode(m);
    repeat (8) begin
      cmd(4'h1, 2'h0, 12'h0, 16'h0, k);
      nop(2);
    end
  endtask : init

  task automatic act(input logic [1:0] ba);
    int k;
    cmd(4'h3, ba, 12'h0, 16'h0, k);
    nop(2);
  endtask : act

  task automatic wr(input logic [1:0] ba, input logic [11:0] a, input int n, input logic [15:0] b);
    int k;
    cmd(4'h4, ba, a, b, k);
    for (int i = 1; i < n; i++) cmd(4'h7, 2'h0, 12'h0, b + 16'(i), k);
  endtask : wr

  task automatic rd(input logic [1:0] ba, input logic [11:0] a, output int k);
    cmd(4'h5, ba, a, 16'ha5a5 ^ 16'(edge_n), k);
  endtask : rd

  task automatic bst();
    int k;
    cmd(4'h6, 2'h0, 12'h0, 16'h0, k);
  endtask : bst
endmodule : sdram_ctrl_model

// [verif/sdram_burst_tb.sv]
// self-checking bench for the sdram burst block
`timescale 1ns/1ps
`include "sdram_burst_regs.svh"
module sdram_burst_tb
  import sdram_burst_pkg::*;
;
  logic        aclk, aresetn, ce, sd_clk;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0]  s_bresp, s_rresp, dq_oe;
  logic [15:0] dq_o;
  pins_t       sd_pins;
  int          err_total = 0;
  int          n_tests = 0;
  int          k, k2;
  logic [15:0] mem [0:255];

  sdram_burst i_sdram_burst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .sd_clk(sd_clk), .sd_pins(sd_pins), .dq_o(dq_o), .dq_oe(dq_oe)
  );

  sdram_ctrl_model i_sdram_ctrl_model (
    .sd_clk(sd_clk), .sd_pins(sd_pins), .dq_o(dq_o), .dq_oe(dq_oe)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic test_done();
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input logic [1:0] gr, input logic [1:0] er);
    n_tests++;
    if (g !== e || gr !== er) begin
      err_total++;
      $display("mismatch at %0t: reg %h resp %h, want %h resp %h", $time, g, gr, e, er);
    end
  endtask : chk32

  // an idle beat must not drive; its data is not looked at
  task automatic chk_dq(input int i, input logic [1:0] eo, input logic [15:0] e);
    logic [15:0] g;
    g = (eo === 2'b00) ? e : i_sdram_ctrl_model.cap_d[i];
    n_tests++;
    if (i_sdram_ctrl_model.cap_oe[i] !== eo || g !== e) begin
      err_total++;
      $display("mismatch at %0t: link beat %0d oe %b data %h, want %b %h", $time, i,
               i_sdram_ctrl_model.cap_oe[i], g, eo, e);
    end
  endtask : chk_dq

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do @(posedge aclk); while (!(s_awready && s_wready));
    s_awvalid <= 1'b0;
    s_wvalid  <= 1'b0;
    do @(posedge aclk); while (!s_bvalid);
    s_bready  <= 1'b0;
    chk32(32'h0, 32'h0, s_bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_rvalid);
    s_rready  <= 1'b0;
    chk32(s_rdata, e, s_rresp, er);
  endtask : axi_rd

  // expected array follows sequential bl8 writes; beats past the burst are dropped
  task automatic wr(input logic [1:0] ba, input logic [5:0] c, input int n, input logic [15:0] b);
    for (int i = 0; i < n && i < 8; i++) mem[{ba, c[5:3], c[2:0] + 3'(i)}] = b + 16'(i);
    i_sdram_ctrl_model.wr(ba, {6'h0, c}, n, b);
  endtask : wr

  task automatic rd8(input logic [1:0] ba, input logic [5:0] c, input int cl, input logic il);
    int j;
    i_sdram_ctrl_model.rd(ba, {6'h0, c}, j);
    i_sdram_ctrl_model.nop(cl + 9);
    for (int i = 0; i < 8; i++)
      chk_dq(j + cl + i, 2'b11, mem[{ba, c[5:3], il ? c[2:0] ^ 3'(i) : c[2:0] + 3'(i)}]);
    chk_dq(j + cl + 8, 2'b00, 16'h0);
  endtask : rd8

  initial begin
    #5_000_000;
    err_total++;
    test_done();
  end

  initial begin
    {aresetn, s_awvalid, s_wvalid, s_arvalid, s_bready, s_rready} = '0;
    ce = 1'b1;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata  = 32'h0;
    s_wstrb  = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CTRL_OFF, `CTRL_RST, `RESP_OKAY);
    axi_rd(`STATUS_OFF, 32'h0, `RESP_OKAY);
    axi_rd(8'h08, 32'h0, `RESP_SLVERR);
    axi_wr(`STATUS_OFF, 32'hffff_ffff, `RESP_SLVERR);
    axi_wr(8'h0c, 32'h1, `RESP_SLVERR);
    axi_wr(`CTRL_OFF, 32'h0, `RESP_OKAY);
    axi_rd(`CTRL_OFF, 32'h0, `RESP_OKAY);
    // disabled block must ignore a mode load
    i_sdram_ctrl_model.set_mode(12'h023);
    axi_rd(`STATUS_OFF, 32'h0, `RESP_OKAY);
    // a frozen block must hold the write off until the enable returns
    ce <= 1'b0;
    fork
      axi_wr(`CTRL_OFF, 32'h1, `RESP_OKAY);
      begin
        repeat (5) @(posedge aclk);
        ce <= 1'b1;
      end
    join
    s_wstrb <= 4'he;
    axi_wr(`CTRL_OFF, 32'h0, `RESP_OKAY);
    s_wstrb <= 4'hf;
    axi_rd(`CTRL_OFF, 32'h1, `RESP_OKAY);
    i_sdram_ctrl_model.init(12'h023);
    axi_rd(`STATUS_OFF, 32'h0018_0023, `RESP_OKAY);
    i_sdram_ctrl_model.act(2'h1);
    wr(2'h1, 6'h00, 10, 16'h1000);
    i_sdram_ctrl_model.nop(2);
    axi_rd(`STATUS_OFF, 32'h0018_2023, `RESP_OKAY);
    rd8(2'h1, 6'h03, 2, 1'b0);
    i_sdram_ctrl_model.rd(2'h1, 12'h005, k);
    i_sdram_ctrl_model.rd(2'h1, 12'h000, k2);
    i_sdram_ctrl_model.nop(12);
    chk_dq(k + 2, 2'b11, mem[8'h45]);
    for (int i = 0; i < 8; i++) chk_dq(k2 + 2 + i, 2'b11, mem[8'h40 + 8'(i)]);
    wr(2'h1, 6'h00, 1, 16'h2000);
    rd8(2'h1, 6'h00, 2, 1'b0);
    // write cuts a read; the mask keeps the two overlapping read beats off the bus
    i_sdram_ctrl_model.dqm_q = 2'h3;
    i_sdram_ctrl_model.rd(2'h1, 12'h000, k);
    i_sdram_ctrl_model.nop(1);
    i_sdram_ctrl_model.dqm_q = 2'h0;
    wr(2'h1, 6'h00, 8, 16'h2100);
    chk_dq(k + 2, 2'b00, 16'h0);
    chk_dq(k + 3, 2'b00, 16'h0);
    i_sdram_ctrl_model.act(2'h2);
    wr(2'h1, 6'h00, 2, 16'h3000);
    wr(2'h2, 6'h00, 8, 16'h4000);
    i_sdram_ctrl_model.nop(2);
    rd8(2'h1, 6'h00, 2, 1'b0);
    rd8(2'h2, 6'h00, 2, 1'b0);
    i_sdram_ctrl_model.set_mode(12'h03b);
    i_sdram_ctrl_model.act(2'h1);
    rd8(2'h1, 6'h05, 3, 1'b1);
    i_sdram_ctrl_model.set_mode(12'h027);
    i_sdram_ctrl_model.act(2'h1);
    i_sdram_ctrl_model.rd(2'h1, 12'h006, k);
    i_sdram_ctrl_model.nop(1);
    i_sdram_ctrl_model.bst();
    i_sdram_ctrl_model.nop(6);
    chk_dq(k + 2, 2'b11, mem[8'h46]);
    chk_dq(k + 3, 2'b11, mem[8'h47]);
    chk_dq(k + 4, 2'b00, 16'h0);
    // a read pattern with chip select high must start nothing
    i_sdram_ctrl_model.cmd(4'hd, 2'h1, 12'h000, 16'h0, k);
    i_sdram_ctrl_model.nop(4);
    chk_dq(k + 2, 2'b00, 16'h0);
    axi_rd(`STATUS_OFF, 32'h0018_2027, `RESP_OKAY);
    test_done();
  end
endmodule : sdram_burst_tb
